// file: rtl/crpc_top.sv
// Function
// - Main rail on only while request low
// - Main outputs off within 5 ms
// - Main rail up 5 to 400 ms
// - Power-good drops within 5 ms
// - Power-good high only when in regulation, or held in standby
// - Power-good low on undervoltage or input loss
// - No power-good timing during current limit
// - Power-good 100 to 500 ms after regulation
// - Standby on control pin high, light load
// - Configuration byte at command D0h
// - Value 00h standard sharing, blocks others
// - Value 01h unit always stays on
// - Value 02h off third after 800 ms
// - Value 03h off second after 600 ms
// - Value 04h off first after 400 ms
// - Any fault resets configuration to 00h
// - Standby needs request, fault line high, position
// - Standby keeps power-good, wakes on demand
// - Standby hides faults, fault exits standby
// - Standby blinks green, amber on warning
// - Load-share threshold set per position
// - Active unit pulls fault line low in 00h or on warning or fault
`timescale 1ns/10ps
`default_nettype none
`include "crpc_consts.svh"

module crpc_top
  import crpc_pkg::*;
#(
  parameter int unsigned T_ON_CYC    = `CRPC_T_ON_CYC,
  parameter int unsigned T_PG_CYC    = `CRPC_T_PG_CYC,
  parameter int unsigned T_OFF1_CYC  = `CRPC_T_OFF1_CYC,
  parameter int unsigned T_OFF2_CYC  = `CRPC_T_OFF2_CYC,
  parameter int unsigned T_OFF3_CYC  = `CRPC_T_OFF3_CYC,
  parameter int unsigned T_BLINK_CYC = `CRPC_T_BLINK_CYC,
  parameter int unsigned T_HOLD_CYC  = `CRPC_T_HOLD_CYC,
  parameter int unsigned T_FILT_CYC  = `CRPC_T_FILT_CYC
) (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // System pins
  input  wire logic       power_on_request_pin_n,
  input  wire logic       wake_pin,
  input  wire logic       shared_redundancy_fault_n_i,
  output var  logic       shared_redundancy_fault_n_o,
  output var  logic       shared_redundancy_fault_n_oe,
  // Byte command port from the bus controller
  input  wire crpc_byte_t cmd_code,
  input  wire logic       cmd_wr,
  input  wire logic       cmd_rd,
  input  wire crpc_byte_t cmd_wdata,
  output var  crpc_byte_t cmd_rdata,
  output var  logic       cmd_ack,
  output var  logic       cmd_nak,
  // Protection and analog status
  input  wire logic       rail_in_reg,
  input  wire logic       rail_cur_limit,
  input  wire logic       input_power_ok,
  input  wire logic       fault_any,
  input  wire logic       warn_any,
  input  wire logic       load_share_above,
  // Rail, status and indicator outputs
  output var  logic       main_rail_en,
  output var  logic       standby_rail_en,
  output var  logic       power_good,
  output var  logic       smart_standby,
  output var  logic       status_fault_report,
  output var  logic       led_green,
  output var  logic       led_amber,
  output var  logic [1:0] load_share_pos
);

  //--------------------------------------------------------------
  // Limits and state
  //--------------------------------------------------------------

  localparam crpc_cnt_t L_ON    = crpc_cnt_t'(T_ON_CYC - 1);
  localparam crpc_cnt_t L_PG    = crpc_cnt_t'(T_PG_CYC - 1);
  localparam crpc_cnt_t L_OFF1  = crpc_cnt_t'(T_OFF1_CYC - 1);
  localparam crpc_cnt_t L_OFF2  = crpc_cnt_t'(T_OFF2_CYC - 1);
  localparam crpc_cnt_t L_OFF3  = crpc_cnt_t'(T_OFF3_CYC - 1);
  localparam crpc_cnt_t L_BLINK = crpc_cnt_t'(T_BLINK_CYC - 1);
  localparam crpc_cnt_t L_HOLD  = crpc_cnt_t'(T_HOLD_CYC);

  typedef struct packed {
    crpc_state_e st;
    crpc_cnt_t   dly;
    crpc_cnt_t   pg_cnt;
    crpc_cnt_t   blink_cnt;
    crpc_cnt_t   hold_cnt;
    logic        blink;
    logic        req_q;
    logic        main_en;
    logic        sb_rail;
    logic        pg;
    logic        stby;
    logic        fault_rep;
    logic        led_g;
    logic        led_a;
    logic        red_drv;
    logic [1:0]  ls_pos;
  } crpc_top_s;

  crpc_top_s r, nxt;

  //--------------------------------------------------------------
  // Submodules
  //--------------------------------------------------------------

  crpc_core_if core_if ();

  crpc_in_filter #(
    .N        (`CRPC_IN_COUNT),
    .FILT_CYC (int'(T_FILT_CYC))
  ) u_filter (
    .sys_clk (sys_clk),
    .rstn    (rstn),
    .pin_raw ({shared_redundancy_fault_n_i, wake_pin, power_on_request_pin_n}),
    .core    (core_if.filt)
  );

  crpc_cfg_reg u_cfg (
    .sys_clk   (sys_clk),
    .rstn      (rstn),
    .cmd_code  (cmd_code),
    .cmd_wr    (cmd_wr),
    .cmd_rd    (cmd_rd),
    .cmd_wdata (cmd_wdata),
    .cmd_rdata (cmd_rdata),
    .cmd_ack   (cmd_ack),
    .cmd_nak   (cmd_nak),
    .core      (core_if.cfg)
  );

  // Faults feed the configuration reset
  assign core_if.fault = fault_any;

  //--------------------------------------------------------------
  // Decoded conditions
  //--------------------------------------------------------------

  logic       req_on;
  logic       wake_hi;
  logic       red_ok;
  logic       sb_cfg;
  logic       std_cfg;
  logic       stby_cond;
  logic       wake_exit;
  logic       main_act;
  logic       rel_evt;
  crpc_cnt_t  off_lim;
  logic [1:0] pos;

  // Filtered pin levels
  assign req_on  = !core_if.filt_lvl[`CRPC_IN_REQ_N];
  assign wake_hi = core_if.filt_lvl[`CRPC_IN_WAKE];
  assign red_ok  = core_if.filt_lvl[`CRPC_IN_RED_N];

  // Configuration class
  assign std_cfg = (core_if.cfg_val == `CRPC_CFG_STANDARD);
  assign sb_cfg  = (core_if.cfg_val >= `CRPC_CFG_STBY1) &&
                   (core_if.cfg_val <= `CRPC_CFG_STBY_MAX);

  // Position and off delay per configuration
  always_comb begin
    case (core_if.cfg_val)
      `CRPC_CFG_STBY1: begin
        pos     = 2'd1;
        off_lim = L_OFF1;
      end
      `CRPC_CFG_STBY2: begin
        pos     = 2'd2;
        off_lim = L_OFF2;
      end
      `CRPC_CFG_STBY3, `CRPC_CFG_STBY_MAX: begin
        pos     = 2'd3;
        off_lim = L_OFF3;
      end
      default: begin
        pos     = 2'd0;
        off_lim = L_OFF3;
      end
    endcase
  end

  assign stby_cond = req_on && red_ok && sb_cfg && wake_hi &&
                     !load_share_above && !fault_any;

  // wake on pin low or fault line
  assign wake_exit = !wake_hi || !red_ok || load_share_above ||
                     !sb_cfg || fault_any;

  // Unit sourcing main power
  assign main_act = r.main_en;

  // Request released while powered
  assign rel_evt = r.req_q && !req_on && r.main_en;

  //--------------------------------------------------------------
  // Next-state logic
  //--------------------------------------------------------------

  always_comb begin
    nxt         = r;
    nxt.req_q   = req_on;
    nxt.sb_rail = 1'b1;

    // Main sequencer
    case (r.st)
      ST_OFF: begin
        nxt.dly = '0;
        if (req_on) begin
          nxt.st = ST_ON_DLY;
        end
      end
      ST_ON_DLY: begin
        if (!req_on) begin
          nxt.st  = ST_OFF;
          nxt.dly = '0;
        end else if (r.dly == L_ON) begin
          nxt.st  = ST_ON;
          nxt.dly = '0;
        end else begin
          nxt.dly = r.dly + 1'b1;
        end
      end
      ST_ON: begin
        nxt.dly = '0;
        if (!req_on) begin
          nxt.st = ST_OFF;
        end else if (stby_cond) begin
          nxt.st = ST_SB_DLY;
        end
      end
      ST_SB_DLY: begin
        if (!req_on) begin
          nxt.st  = ST_OFF;
          nxt.dly = '0;
        end else if (!stby_cond) begin
          nxt.st  = ST_ON;
          nxt.dly = '0;
        end else if (r.dly == off_lim) begin
          nxt.st  = ST_STBY;
          nxt.dly = '0;
        end else begin
          nxt.dly = r.dly + 1'b1;
        end
      end
      ST_STBY: begin
        nxt.dly = '0;
        if (!req_on) begin
          nxt.st = ST_OFF;
        end else if (wake_exit) begin
          nxt.st = ST_ON;
        end
      end
      default: begin
        nxt.st  = ST_OFF;
        nxt.dly = '0;
      end
    endcase

    nxt.main_en = (nxt.st == ST_ON) || (nxt.st == ST_SB_DLY);
    nxt.stby    = (nxt.st == ST_STBY);

    // Power-good timing
    if (!input_power_ok || !req_on) begin
      nxt.pg     = 1'b0;
      nxt.pg_cnt = '0;
    end else if (nxt.st == ST_STBY) begin
      nxt.pg_cnt = '0;
    end else if (!nxt.main_en || !rail_in_reg) begin
      nxt.pg     = 1'b0;
      nxt.pg_cnt = '0;
    end else if (!r.pg) begin
      if (rail_cur_limit) begin
        nxt.pg_cnt = '0;
      end else if (r.pg_cnt == L_PG) begin
        nxt.pg     = 1'b1;
        nxt.pg_cnt = '0;
      end else begin
        nxt.pg_cnt = r.pg_cnt + 1'b1;
      end
    end

    // Blink timebase
    if (r.blink_cnt == L_BLINK) begin
      nxt.blink_cnt = '0;
      nxt.blink     = !r.blink;
    end else begin
      nxt.blink_cnt = r.blink_cnt + 1'b1;
    end

    // Indicator
    if (nxt.stby) begin
      nxt.led_g = r.blink && !warn_any;
      nxt.led_a = r.blink && warn_any;
    end else begin
      nxt.led_g = nxt.pg && !warn_any && !fault_any;
      nxt.led_a = warn_any || fault_any;
    end

    nxt.fault_rep = (fault_any || warn_any) && !nxt.stby;

    // Hold the fault line after one-shot events
    if (core_if.cfg_zero_wr || rel_evt) begin
      nxt.hold_cnt = L_HOLD;
    end else if (r.hold_cnt != '0) begin
      nxt.hold_cnt = r.hold_cnt - 1'b1;
    end

    nxt.red_drv = (main_act && (warn_any || fault_any || std_cfg)) ||
                  (r.hold_cnt != '0) || core_if.cfg_zero_wr || rel_evt;

    nxt.ls_pos = pos;
  end

  //--------------------------------------------------------------
  // State register
  //--------------------------------------------------------------

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{st: ST_OFF, dly: '0, pg_cnt: '0, blink_cnt: '0,
             hold_cnt: '0, blink: 1'b0, req_q: 1'b0, main_en: 1'b0,
             sb_rail: 1'b1, pg: 1'b0, stby: 1'b0, fault_rep: 1'b0,
             led_g: 1'b0, led_a: 1'b0, red_drv: 1'b0, ls_pos: 2'd0};
    end else begin
      r <= nxt;
    end
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------

  assign main_rail_en                 = r.main_en;
  assign standby_rail_en              = r.sb_rail;
  assign power_good                   = r.pg;
  assign smart_standby                = r.stby;
  assign status_fault_report          = r.fault_rep;
  assign led_green                    = r.led_g;
  assign led_amber                    = r.led_a;
  assign load_share_pos               = r.ls_pos;
  // Open drain: only ever pulls low
  assign shared_redundancy_fault_n_o  = 1'b0;
  assign shared_redundancy_fault_n_oe = r.red_drv;

endmodule : crpc_top

`default_nettype wire

// file: pkg/crpc_consts.svh
`ifndef CRPC_CONSTS_SVH
`define CRPC_CONSTS_SVH

// Command code of the configuration byte
`define CRPC_CMD_CONFIG   8'hd0
// Configuration values
`define CRPC_CFG_RESET    8'h00
`define CRPC_CFG_STANDARD 8'h00
`define CRPC_CFG_ACTIVE   8'h01
`define CRPC_CFG_STBY1    8'h02
`define CRPC_CFG_STBY2    8'h03
`define CRPC_CFG_STBY3    8'h04
`define CRPC_CFG_STBY_MAX 8'h05
// Filtered input bit positions
`define CRPC_IN_REQ_N     0
`define CRPC_IN_WAKE      1
`define CRPC_IN_RED_N     2
`define CRPC_IN_COUNT     3
// Clock rate and times
`define CRPC_CLK_KHZ      125000
`define CRPC_T_ON_MS      5
`define CRPC_T_PG_MS      100
`define CRPC_T_OFF1_MS    800
`define CRPC_T_OFF2_MS    600
`define CRPC_T_OFF3_MS    400
`define CRPC_T_BLINK_MS   500
`define CRPC_T_HOLD_MS    1
`define CRPC_T_FILT_US    1
// Cycle counts derived from the times
`define CRPC_T_ON_CYC     (`CRPC_T_ON_MS * `CRPC_CLK_KHZ)
`define CRPC_T_PG_CYC     (`CRPC_T_PG_MS * `CRPC_CLK_KHZ)
`define CRPC_T_OFF1_CYC   (`CRPC_T_OFF1_MS * `CRPC_CLK_KHZ)
`define CRPC_T_OFF2_CYC   (`CRPC_T_OFF2_MS * `CRPC_CLK_KHZ)
`define CRPC_T_OFF3_CYC   (`CRPC_T_OFF3_MS * `CRPC_CLK_KHZ)
`define CRPC_T_BLINK_CYC  (`CRPC_T_BLINK_MS * `CRPC_CLK_KHZ)
`define CRPC_T_HOLD_CYC   (`CRPC_T_HOLD_MS * `CRPC_CLK_KHZ)
`define CRPC_T_FILT_CYC   ((`CRPC_T_FILT_US * `CRPC_CLK_KHZ + 999) / 1000)

`endif

// file: pkg/crpc_pkg.sv
package crpc_pkg;
  // Sequencer states
  typedef enum logic [2:0] {
    ST_OFF    = 3'b000,
    ST_ON_DLY = 3'b001,
    ST_ON     = 3'b010,
    ST_SB_DLY = 3'b011,
    ST_STBY   = 3'b100
  } crpc_state_e;
  // Long timer counter, holds up to 800 ms of cycles
  typedef logic [26:0] crpc_cnt_t;
  typedef logic [7:0]  crpc_byte_t;
endpackage : crpc_pkg

// file: pkg/crpc_core_if.sv
`timescale 1ns/10ps
`default_nettype none
`include "crpc_consts.svh"

interface crpc_core_if;
  import crpc_pkg::*;
  logic [`CRPC_IN_COUNT-1:0] filt_lvl;
  crpc_byte_t                cfg_val;
  logic                      cfg_zero_wr;
  logic                      fault;
  modport filt (output filt_lvl);
  modport cfg  (input fault, output cfg_val, output cfg_zero_wr);
  modport core (input filt_lvl, input cfg_val, input cfg_zero_wr, output fault);
endinterface : crpc_core_if

`default_nettype wire

// file: rtl/crpc_in_filter.sv
`timescale 1ns/10ps
`default_nettype none
`include "crpc_consts.svh"

module crpc_in_filter
  import crpc_pkg::*;
#(
  parameter int N        = `CRPC_IN_COUNT,
  parameter int FILT_CYC = `CRPC_T_FILT_CYC
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rstn,
  // Raw pins
  input  wire logic [N-1:0] pin_raw,
  // Filtered levels
  crpc_core_if.filt         core
);
  localparam int CW = $clog2(FILT_CYC + 1);
  typedef struct packed {
    logic          s1;
    logic          s2;
    logic          lvl;
    logic [CW-1:0] cnt;
  } crpc_filt_s;
  logic [N-1:0] lvl;

  // Two-stage sync, then level must hold FILT_CYC cycles
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      crpc_filt_s st_r, st_nxt;
      always_comb begin
        st_nxt    = st_r;
        st_nxt.s1 = pin_raw[i];
        st_nxt.s2 = st_r.s1;
        if (st_r.s2 == st_r.lvl) begin
          st_nxt.cnt = '0;
        end else if (st_r.cnt == CW'(FILT_CYC - 1)) begin
          st_nxt.lvl = st_r.s2;
          st_nxt.cnt = '0;
        end else begin
          st_nxt.cnt = st_r.cnt + 1'b1;
        end
      end
      // Pins idle high through pull-ups
      always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
          st_r <= '{s1: 1'b1, s2: 1'b1, lvl: 1'b1, cnt: '0};
        end else begin
          st_r <= st_nxt;
        end
      end
      assign lvl[i] = st_r.lvl;
    end
  endgenerate

  assign core.filt_lvl = lvl;
endmodule : crpc_in_filter

`default_nettype wire

// file: rtl/crpc_cfg_reg.sv
`timescale 1ns/10ps
`default_nettype none
`include "crpc_consts.svh"

module crpc_cfg_reg
  import crpc_pkg::*;
(
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rstn,
  // Byte command port
  input  wire crpc_byte_t cmd_code,
  input  wire logic       cmd_wr,
  input  wire logic       cmd_rd,
  input  wire crpc_byte_t cmd_wdata,
  output var  crpc_byte_t cmd_rdata,
  output var  logic       cmd_ack,
  output var  logic       cmd_nak,
  // Core link
  crpc_core_if.cfg        core
);
  typedef struct packed {
    crpc_byte_t cfg;
    crpc_byte_t rdata;
    logic       ack;
    logic       nak;
    logic       zero_wr;
  } crpc_cfg_s;
  crpc_cfg_s r, nxt;
  logic      hit;
  logic      val_ok;

  // Decode, answer and update
  always_comb begin
    hit         = (cmd_code == `CRPC_CMD_CONFIG);
    val_ok      = (cmd_wdata <= `CRPC_CFG_STBY_MAX);
    nxt         = r;
    nxt.ack     = 1'b0;
    nxt.nak     = 1'b0;
    nxt.zero_wr = 1'b0;
    if (cmd_wr || cmd_rd) begin
      nxt.ack = hit && (cmd_rd || val_ok);
      nxt.nak = !(hit && (cmd_rd || val_ok));
    end
    if (cmd_rd) begin
      nxt.rdata = hit ? r.cfg : 8'h00;
    end
    if (cmd_wr && hit && val_ok) begin
      nxt.cfg     = cmd_wdata;
      nxt.zero_wr = (cmd_wdata == `CRPC_CFG_STANDARD);
    end
    if (core.fault) begin
      nxt.cfg = `CRPC_CFG_RESET;
    end
  end

  // State register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      r <= '{cfg: `CRPC_CFG_RESET, rdata: 8'h00, ack: 1'b0, nak: 1'b0, zero_wr: 1'b0};
    end else begin
      r <= nxt;
    end
  end

  assign cmd_rdata        = r.rdata;
  assign cmd_ack          = r.ack;
  assign cmd_nak          = r.nak;
  assign core.cfg_val     = r.cfg;
  assign core.cfg_zero_wr = r.zero_wr;
endmodule : crpc_cfg_reg

`default_nettype wire

// file: verif/crpc_top_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "crpc_consts.svh"

module crpc_top_properties
  import crpc_pkg::*;
#(
  parameter int unsigned T_ON_CYC = `CRPC_T_ON_CYC,
  parameter int unsigned T_PG_CYC = `CRPC_T_PG_CYC
) (
  // Clock and reset
  input wire logic       sys_clk,
  input wire logic       rstn,
  // Pins and status
  input wire logic       power_on_request_pin_n,
  input wire logic       shared_redundancy_fault_n_oe,
  input wire logic       rail_in_reg,
  input wire logic       rail_cur_limit,
  input wire logic       input_power_ok,
  input wire logic       fault_any,
  // Command port
  input wire crpc_byte_t cmd_code,
  input wire logic       cmd_wr,
  input wire logic       cmd_rd,
  input wire crpc_byte_t cmd_wdata,
  input wire crpc_byte_t cmd_rdata,
  input wire logic       cmd_ack,
  input wire logic       cmd_nak,
  // Rail and state outputs
  input wire logic       main_rail_en,
  input wire logic       power_good,
  input wire logic       smart_standby,
  input wire logic       status_fault_report
);
  // ------
  // Helpers
  // ------
  typedef struct packed {
    crpc_byte_t  cfg;
    logic [15:0] ok;
    logic [15:0] req;
  } crpc_chk_s;
  crpc_chk_s st_r;
  crpc_chk_s st_nxt;
  logic      ok_now;

  // Shadow config, run lengths of good rails and of request
  always_comb begin
    st_nxt = st_r;
    ok_now = rail_in_reg && !rail_cur_limit && input_power_ok;
    if (fault_any) begin
      st_nxt.cfg = 8'h00;
    end else if (cmd_wr && cmd_code == `CRPC_CMD_CONFIG && cmd_wdata <= 8'h05) begin
      st_nxt.cfg = cmd_wdata;
    end
    st_nxt.ok  = ok_now ? st_r.ok + {15'h0, ~&st_r.ok} : 16'h0000;
    st_nxt.req = power_on_request_pin_n ? 16'h0000 : st_r.req + {15'h0, ~&st_r.req};
  end

  // Helper register
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ------
  // Properties
  // ------
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!rstn);

  rail_off_a: assert property (
    power_on_request_pin_n [*8] |-> ##2 (!main_rail_en && !power_good))
    else $error("Rail or power good up after release");
  main_up_min_a: assert property (
    $rose(main_rail_en) && !$past(smart_standby) |-> st_r.req >= T_ON_CYC)
    else $error("Main rail up too early");
  main_up_max_a: assert property (
    st_r.req == 16'(T_ON_CYC + 16) |-> main_rail_en || smart_standby)
    else $error("Main rail up too late");
  pg_delay_a: assert property (
    $rose(power_good) |-> st_r.ok >= T_PG_CYC)
    else $error("Power good before its delay");
  pg_in_reg_a: assert property (
    !smart_standby && !(rail_in_reg && input_power_ok) |=> !power_good)
    else $error("Power good without regulation");
  answer_once_a: assert property (
    (cmd_wr || cmd_rd) |=> (cmd_ack ^ cmd_nak))
    else $error("Command not answered once");
  refuse_bad_a: assert property (
    (cmd_wr || cmd_rd) && (cmd_code != `CRPC_CMD_CONFIG || (cmd_wr && cmd_wdata > 8'h05))
    |=> cmd_nak)
    else $error("Bad command not refused");
  read_back_a: assert property (
    cmd_rd && cmd_code == `CRPC_CMD_CONFIG |=> cmd_rdata == $past(st_r.cfg))
    else $error("Read data differs from config");
  standby_hold_a: assert property (
    smart_standby |-> power_good && !main_rail_en && !status_fault_report)
    else $error("Standby outputs wrong");
  standby_cfg_a: assert property (
    $rose(smart_standby) |-> st_r.cfg inside {[8'h02:8'h05]})
    else $error("Standby entered with wrong config");
  fault_exit_a: assert property (
    smart_standby && fault_any |=> !smart_standby && main_rail_en)
    else $error("Fault did not end standby");
  cfg00_pull_a: assert property (
    (main_rail_en && st_r.cfg == 8'h00) [*2] |-> shared_redundancy_fault_n_oe)
    else $error("Fault line not pulled in standard mode");
endmodule : crpc_top_properties

bind crpc_top crpc_top_properties #(.T_ON_CYC(T_ON_CYC), .T_PG_CYC(T_PG_CYC)) u_props (
  .sys_clk, .rstn, .power_on_request_pin_n, .shared_redundancy_fault_n_oe,
  .rail_in_reg, .rail_cur_limit, .input_power_ok, .fault_any, .cmd_code, .cmd_wr,
  .cmd_rd, .cmd_wdata, .cmd_rdata, .cmd_ack, .cmd_nak, .main_rail_en, .power_good,
  .smart_standby, .status_fault_report
);

`default_nettype wire

// file: verif/crpc_peer_model.sv
`timescale 1ns/10ps
`default_nettype none

module crpc_peer_model (
  // Drivers of the shared line
  input  wire logic dut_o,
  input  wire logic dut_oe,
  input  wire logic peer_pull,
  // Resolved line
  output wire logic line_n
);
  // other unit pulls low
  // Open drain with pull-up: low while anyone pulls
  assign line_n = ((dut_oe && !dut_o) || peer_pull) ? 1'b0 : 1'b1;
endmodule : crpc_peer_model

`default_nettype wire

// file: verif/tb_crpc_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "crpc_consts.svh"

module tb_crpc_top
  import crpc_pkg::*;
;
  // ------
  // Bench signals
  // ------
  localparam int TON = 20;
  localparam int TPG = 30;
  localparam int TBL = 8;
  localparam crpc_byte_t CFG = `CRPC_CMD_CONFIG;
  logic       sys_clk, rstn, power_on_request_pin_n, wake_pin, line_n, red_o, red_oe;
  logic       cmd_wr, cmd_rd, cmd_ack, cmd_nak, peer_pull, stby_on, load_share_above;
  logic       rail_in_reg, rail_cur_limit, input_power_ok, fault_any, warn_any;
  logic       main_rail_en, standby_rail_en, power_good, status_fault_report;
  logic       led_green, led_amber;
  logic [1:0] load_share_pos;
  crpc_byte_t cmd_code, cmd_wdata, cmd_rdata;
  int         err_count = 0;
  int         comparisons = 0;

  // Device and far side
  crpc_top #(.T_ON_CYC(TON), .T_PG_CYC(TPG), .T_OFF1_CYC(40), .T_OFF2_CYC(30),
    .T_OFF3_CYC(20), .T_BLINK_CYC(TBL), .T_HOLD_CYC(5), .T_FILT_CYC(3)) dut (
    .sys_clk, .rstn, .power_on_request_pin_n, .wake_pin, .shared_redundancy_fault_n_i(line_n),
    .shared_redundancy_fault_n_o(red_o), .shared_redundancy_fault_n_oe(red_oe), .cmd_code,
    .cmd_wr, .cmd_rd, .cmd_wdata, .cmd_rdata, .cmd_ack, .cmd_nak, .rail_in_reg,
    .rail_cur_limit, .input_power_ok, .fault_any, .warn_any, .load_share_above,
    .main_rail_en, .standby_rail_en, .power_good, .smart_standby(stby_on),
    .status_fault_report, .led_green, .led_amber, .load_share_pos);
  crpc_peer_model peer (.dut_o(red_o), .dut_oe(red_oe), .peer_pull(peer_pull), .line_n(line_n));

  // ------
  // Helpers
  // ------
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : tick

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic cmd(input logic wr, input crpc_byte_t code, input crpc_byte_t wd,
                     input logic ok, input crpc_byte_t rd);
    tick(1);
    {cmd_wr, cmd_rd, cmd_code, cmd_wdata} = {wr, !wr, code, wd};
    tick(1);
    {cmd_wr, cmd_rd} = 2'b00;
    check(cmd_ack, ok);
    check(cmd_nak, !ok);
    if (!wr) check(cmd_rdata, rd);
  endtask : cmd

  function automatic logic pick(input int sel);
    case (sel)
      0: pick = main_rail_en;
      1: pick = power_good;
      default: pick = stby_on;
    endcase
  endfunction : pick

  task automatic wait_sig(input int sel, input logic v, output int n);
    n = 0;
    while (pick(sel) !== v && n < 500) begin
      tick(1);
      n++;
    end
  endtask : wait_sig

  // ------
  // Scenarios
  // ------
  task automatic t_regs;
    cmd(1'b0, CFG, 8'h00, 1'b1, 8'h00);
    check(standby_rail_en, 1'b1);
    for (int v = 0; v < 6; v++) begin
      cmd(1'b1, CFG, 8'(v), 1'b1, 8'h00);
      cmd(1'b0, CFG, 8'h00, 1'b1, 8'(v));
    end
    cmd(1'b1, CFG, 8'h06, 1'b0, 8'h00);
    cmd(1'b0, 8'hd1, 8'h00, 1'b0, 8'h00);
    cmd(1'b0, CFG, 8'h00, 1'b1, 8'h05);
    fault_any = 1'b1;
    tick(1);
    fault_any = 1'b0;
    cmd(1'b0, CFG, 8'h00, 1'b1, 8'h00);
  endtask : t_regs

  task automatic t_power_up;
    int n;
    power_on_request_pin_n = 1'b0;
    wait_sig(0, 1'b1, n);
    check(n >= TON && n <= TON + 16, 1'b1);
    {rail_in_reg, rail_cur_limit} = 2'b11;
    tick(10);
    check(power_good, 1'b0);
    rail_cur_limit = 1'b0;
    wait_sig(1, 1'b1, n);
    check(n >= TPG && n <= TPG + 3, 1'b1);
    check(red_oe, 1'b1);
    rail_in_reg = 1'b0;
    tick(2);
    check(power_good, 1'b0);
    rail_in_reg = 1'b1;
    wait_sig(1, 1'b1, n);
    input_power_ok = 1'b0;
    tick(2);
    check(power_good, 1'b0);
    input_power_ok = 1'b1;
    wait_sig(1, 1'b1, n);
  endtask : t_power_up

  task automatic t_modes;
    cmd(1'b1, CFG, 8'h01, 1'b1, 8'h00);
    tick(60);
    check(stby_on, 1'b0);
    peer_pull = 1'b1;
    cmd(1'b1, CFG, 8'h02, 1'b1, 8'h00);
    tick(60);
    check(stby_on, 1'b0);
    peer_pull = 1'b0;
  endtask : t_modes

  task automatic t_standby(input crpc_byte_t cfg, input int toff, input logic [1:0] pos,
                           input int kind);
    int n;
    int c;
    cmd(1'b1, CFG, 8'h00, 1'b1, 8'h00);
    tick(10);
    check(line_n, 1'b0);
    cmd(1'b1, CFG, cfg, 1'b1, 8'h00);
    wait_sig(2, 1'b1, n);
    check(n >= toff && n <= toff + 15, 1'b1);
    check(main_rail_en, 1'b0);
    check(load_share_pos, pos);
    warn_any = (kind == 1);
    tick(2);
    c = 0;
    repeat (4 * TBL) begin
      tick(1);
      c += int'((warn_any ? led_amber : led_green) === 1'b1);
    end
    check(8'(c), 8'(2 * TBL));
    check(status_fault_report, 1'b0);
    case (kind)
      0: wake_pin = 1'b0;
      1: load_share_above = 1'b1;
      2: peer_pull = 1'b1;
      default: fault_any = 1'b1;
    endcase
    wait_sig(0, 1'b1, n);
    check(n <= 12, 1'b1);
    check(status_fault_report, (kind == 1) || (kind == 3));
    {wake_pin, load_share_above, peer_pull, fault_any, warn_any} = 5'b10000;
    tick(15);
    if (kind == 3) cmd(1'b0, CFG, 8'h00, 1'b1, 8'h00);
  endtask : t_standby

  task automatic t_power_off;
    int n;
    power_on_request_pin_n = 1'b1;
    wait_sig(0, 1'b0, n);
    check(n <= 10, 1'b1);
    check(power_good, 1'b0);
    power_on_request_pin_n = 1'b0;
    tick(2);
    power_on_request_pin_n = 1'b1;
    tick(40);
    check(main_rail_en, 1'b0);
  endtask : t_power_off

  task automatic print_verdict;
    if (err_count == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : print_verdict

  // ------
  // Run
  // ------
  // Clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge sys_clk);
    err_count++;
    print_verdict();
  end

  // Main sequence
  initial begin
    {rstn, power_on_request_pin_n, wake_pin, peer_pull, load_share_above} = 5'b01100;
    {cmd_wr, cmd_rd, cmd_code, cmd_wdata} = '0;
    {rail_in_reg, rail_cur_limit, input_power_ok, fault_any, warn_any} = 5'b00100;
    tick(5);
    rstn = 1'b1;
    t_regs();
    t_power_up();
    t_modes();
    t_standby(8'h02, 40, 2'd1, 0);
    t_standby(8'h03, 30, 2'd2, 1);
    t_standby(8'h04, 20, 2'd3, 2);
    t_standby(8'h05, 20, 2'd3, 3);
    t_power_off();
    print_verdict();
  end
endmodule : tb_crpc_top

`default_nettype wire
